// >>> usblg_top.sv
// legacy keyboard trap, gate pass-through, wake enables and i/o register map
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// [R01] a trapped data-port read sets its flag regardless of its enable
// [R02] data-port read flag stays until software writes one to it
// [R03] enable bit 7 requests an interrupt when a pass-through ends
// [R04] status bit 6 reads one while a pass-through sequence is underway
// [R05] clearing pass-through enable bit 5 resets the in-progress bit
// [R06] bit 5 set runs the gate pass-through sequence; clear disables it
// [R07] no management interrupt while pass-through is enabled
// [R08] enable bit 4 turns a controller interrupt into a management event
// [R09] enable bit 3 turns each command-port write into an event
// [R10] enable bit 2 turns each command-port read into an event
// [R11] enable bit 1 turns each data-port write into an event
// [R12] enable bit 0 turns each data-port read into an event
// [R13] wake enable bit 1 watches port one for wake and connect changes
// [R14] wake enable bit 0 watches port zero for wake and connect changes
// [R15] port state bits read back actual state, not the last write
// [R16] controller, global or port reset aborts and disables affected ports
// [R17] frame start adjust at 0Ch resets to 40h, read and write
// [R18] both port registers reset to 0080h with write-one-to-clear change bits
// [R19] host status resets to zero; its flags clear on written ones
// [R20] read-only loop-back data at 18h resets to 00h, captures loop data
// [R21] interrupt asserts on enabled latched flag with pass-through off, holds
module usblg_top
	import usblg_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// configuration register port
	input  wire logic        cfg_rd,
	input  wire logic        cfg_wr,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [15:0] cfg_wdata,
	output logic      [15:0] cfg_rdata,
	// i/o register port
	input  wire usblg_io_s   io_req,
	output logic      [15:0] io_rdata,
	// legacy keyboard port accesses
	input  wire usblg_kbd_s  kbd,
	// controller events
	input  wire logic [5:0]  hc_status_set,
	input  wire logic        loop_rx_valid,
	input  wire logic [7:0]  loop_rx_data,
	// port pins
	input  wire logic [1:0]  port_attached,
	input  wire logic [1:0]  port_remote_wake,
	// outputs
	output logic             sys_mgmt_interrupt_n,
	output logic             address_line_gate,
	output logic             pci_irq,
	output logic             wake_request,
	output logic      [1:0]  port_enabled
);
	logic [15:0] legkey_r;
	logic [7:0]  wake_en_r;
	logic [15:0] cmd_r;
	logic [15:0] sts_r;
	logic [15:0] intr_r;
	logic [15:0] frame_number_r;
	logic [31:0] base_r;
	logic [7:0]  sof_r;
	logic [7:0]  loop_r;
	logic [15:0] port_r [2];
	logic [1:0]  att_meta_r;
	logic [1:0]  att_r;
	logic [1:0]  wake_meta_r;
	logic [1:0]  rwake_r;
	usblg_pass_e pass_r;
	usblg_pass_e pass_nxt;
	logic        pass_end;
	logic        usb_irq;
	logic [15:0] lk_set;
	logic [15:0] lk_clr;
	logic [15:0] lk_nxt;
	logic        cfg_lk_wr;
	logic [15:0] io_wmask;
	logic        hc_rst;

	// pins come from outside the clock domain
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			att_meta_r  <= 2'h0;
			att_r       <= 2'h0;
			wake_meta_r <= 2'h0;
			rwake_r     <= 2'h0;
		end else begin
			att_meta_r  <= port_attached;
			att_r       <= att_meta_r;
			wake_meta_r <= port_remote_wake;
			rwake_r     <= wake_meta_r;
		end
	end

	assign cfg_lk_wr = cfg_wr && (cfg_addr == CFG_LEGACY_KBD_OFS);
	assign io_wmask  = {{8{io_req.be[1]}}, {8{io_req.be[0]}}};
	assign hc_rst    = cmd_r[CMD_HC_RESET] | cmd_r[CMD_GLB_RESET];
	assign usb_irq   = |(sts_r[3:0] & intr_r[3:0]);

	// gate pass-through sequence: cmd D1, data byte, cmd FF
	always_comb begin
		pass_nxt = pass_r;
		pass_end = 1'b0;
		case (pass_r)
			PASS_IDLE: begin
				if (kbd.cmd_wr && kbd.wdata == GATE_CMD_BYTE)
					pass_nxt = PASS_WAIT_DATA;
			end
			PASS_WAIT_DATA: begin
				if (kbd.data_wr)
					pass_nxt = PASS_WAIT_END;
				else if (kbd.cmd_wr && kbd.wdata != GATE_CMD_BYTE)
					pass_nxt = PASS_IDLE;
			end
			PASS_WAIT_END: begin
				if (kbd.cmd_wr) begin
					pass_nxt = PASS_IDLE;
					pass_end = (kbd.wdata == GATE_END_BYTE);
				end
			end
			default: pass_nxt = PASS_IDLE;
		endcase
		if (!legkey_r[LK_PASS_EN]) begin // R06
			pass_nxt = PASS_IDLE; // R05
			pass_end = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			pass_r <= PASS_IDLE;
		else
			pass_r <= pass_nxt;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			address_line_gate <= 1'b0;
		else if (legkey_r[LK_PASS_EN] && pass_r == PASS_WAIT_DATA && kbd.data_wr)
			address_line_gate <= kbd.wdata[GATE_DATA_BIT]; // R06
	end

	// legacy control register; a set in the clearing cycle wins
	always_comb begin
		lk_set = 16'h0000;
		lk_set[LK_DATA_RD_FLAG] = kbd.data_rd; // R01
		lk_set[LK_DATA_WR_FLAG] = kbd.data_wr;
		lk_set[LK_CMD_RD_FLAG]  = kbd.cmd_rd;
		lk_set[LK_CMD_WR_FLAG]  = kbd.cmd_wr;
		lk_set[LK_END_FLAG]     = pass_end; // R03
		lk_clr = cfg_lk_wr ? (cfg_wdata & LK_W1C_MASK) : 16'h0000; // R02
		lk_nxt = (legkey_r & ~lk_clr) | lk_set;
		if (cfg_lk_wr)
			lk_nxt = (lk_nxt & ~LK_RW_MASK) | (cfg_wdata & LK_RW_MASK);
		lk_nxt[LK_IRQ_FLAG]   = usb_irq;
		lk_nxt[LK_PASS_STATE] = (pass_nxt != PASS_IDLE); // R04
		lk_nxt[14]            = 1'b0;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			legkey_r <= LEGACY_KBD_RST;
		else
			legkey_r <= lk_nxt;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			wake_en_r <= WAKE_PORT_RST;
		else if (cfg_wr && cfg_addr == CFG_WAKE_PORT_OFS)
			wake_en_r <= {6'h00, cfg_wdata[1:0]};
	end

	// latched flag and its enable; released when software clears the flag or its enable, or sets pass-through enable bit 5
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			sys_mgmt_interrupt_n <= 1'b1;
		else
			sys_mgmt_interrupt_n <= legkey_r[LK_PASS_EN] || !( // R07 R21
				(legkey_r[LK_DATA_RD_FLAG] & legkey_r[LK_DATA_RD_EN]) | // R12
				(legkey_r[LK_DATA_WR_FLAG] & legkey_r[LK_DATA_WR_EN]) | // R11
				(legkey_r[LK_CMD_RD_FLAG]  & legkey_r[LK_CMD_RD_EN])  | // R10
				(legkey_r[LK_CMD_WR_FLAG]  & legkey_r[LK_CMD_WR_EN])  | // R09
				(legkey_r[LK_IRQ_FLAG]     & legkey_r[LK_IRQ_SMI_EN]) | // R08
				(legkey_r[LK_END_FLAG]     & legkey_r[LK_SMI_END_EN])); // R03
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			pci_irq <= 1'b0;
		else
			pci_irq <= usb_irq & legkey_r[LK_PIRQ_EN];
	end

	// command register; reset bits abort the ports below
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			cmd_r <= CMD_RST;
		else if (io_req.wr && io_req.addr == IO_CMD_OFS)
			cmd_r <= (cmd_r & ~io_wmask) | (io_req.wdata & io_wmask & CMD_RW_MASK);
		else if (hc_rst)
			cmd_r[CMD_GLB_RESUME] <= 1'b0; // R16
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			sts_r <= STS_RST; // R19
		else if (io_req.wr && io_req.addr == IO_STS_OFS)
			sts_r <= (sts_r & ~(io_req.wdata & io_wmask & STS_W1C_MASK)) | // R19
				{10'h000, hc_status_set};
		else
			sts_r <= sts_r | {10'h000, hc_status_set};
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			intr_r  <= INTR_RST;
			frame_number_r <= FRAME_NUMBER_RST;
			base_r  <= BASE_RST;
			sof_r   <= SOF_RST; // R17
		end else if (io_req.wr) begin
			case (io_req.addr)
				IO_INTR_OFS:  intr_r  <= (intr_r & ~io_wmask) | (io_req.wdata & io_wmask);
				IO_FRAME_NUMBER_OFS: frame_number_r <= (frame_number_r & ~io_wmask) | (io_req.wdata & io_wmask);
				IO_BASE_LO:   base_r[15:0] <= (base_r[15:0] & ~io_wmask) |
						(io_req.wdata & io_wmask);
				IO_BASE_HI:   base_r[31:16] <= (base_r[31:16] & ~io_wmask) |
						(io_req.wdata & io_wmask);
				IO_SOF_OFS: begin
					if (io_req.be[0])
						sof_r <= io_req.wdata[7:0]; // R17
				end
				default: ;
			endcase
		end
	end

	// loop-back capture only while the loop-back mode bit is set
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			loop_r <= LOOP_RST; // R20
		else if (cmd_r[CMD_LOOPBACK] && loop_rx_valid)
			loop_r <= loop_rx_data; // R20
	end

	// per-port status and control
	for (genvar p = 0; p < 2; p++) begin : g_port
		logic        wr_hit;
		logic [15:0] wd;
		logic        att_q;
		logic        en_drop;
		assign wr_hit  = io_req.wr && io_req.addr == (p == 0 ? IO_PORT0_OFS : IO_PORT1_OFS);
		assign wd      = io_req.wdata & io_wmask;
		assign en_drop = hc_rst | port_r[p][PS_PORT_RESET];

		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				port_r[p] <= PORT_RST; // R18
				att_q     <= 1'b0;
			end else begin
				att_q <= att_r[p];
				port_r[p][PS_CONNECT] <= att_r[p]; // R15
				if (wr_hit) begin
					port_r[p][PS_ENABLE]     <= wd[PS_ENABLE] & att_r[p]; // R15
					port_r[p][PS_RESUME]     <= wd[PS_RESUME];
					port_r[p][PS_PORT_RESET] <= wd[PS_PORT_RESET];
					port_r[p][PS_SUSPEND]    <= wd[PS_SUSPEND];
				end
				if (att_q != att_r[p])
					port_r[p][PS_CONN_CHG] <= 1'b1;
				else if (wr_hit && wd[PS_CONN_CHG])
					port_r[p][PS_CONN_CHG] <= 1'b0; // R18
				if (en_drop && port_r[p][PS_ENABLE])
					port_r[p][PS_EN_CHG] <= 1'b1;
				else if (wr_hit && wd[PS_EN_CHG])
					port_r[p][PS_EN_CHG] <= 1'b0; // R18
				if (rwake_r[p] && port_r[p][PS_SUSPEND])
					port_r[p][PS_RESUME] <= 1'b1;
				if (!att_r[p])
					port_r[p][PS_ENABLE] <= 1'b0; // R15
				if (en_drop) begin
					port_r[p][PS_ENABLE]  <= 1'b0; // R16
					port_r[p][PS_RESUME]  <= 1'b0;
					port_r[p][PS_SUSPEND] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			port_enabled <= 2'h0;
			wake_request <= 1'b0;
		end else begin
			port_enabled <= {port_r[1][PS_ENABLE], port_r[0][PS_ENABLE]};
			wake_request <= (wake_en_r[1] & (port_r[1][PS_RESUME] | // R13
				port_r[1][PS_CONN_CHG])) |
				(wake_en_r[0] & (port_r[0][PS_RESUME] | port_r[0][PS_CONN_CHG])); // R14
		end
	end

	// read data registered one cycle after the strobe
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			cfg_rdata <= 16'h0000;
		else if (cfg_rd) begin
			case (cfg_addr)
				CFG_LEGACY_KBD_OFS: cfg_rdata <= legkey_r;
				CFG_WAKE_PORT_OFS:  cfg_rdata <= {8'h00, wake_en_r};
				default:            cfg_rdata <= 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			io_rdata <= 16'h0000;
		else if (io_req.rd) begin
			case (io_req.addr)
				IO_CMD_OFS:   io_rdata <= cmd_r;
				IO_STS_OFS:   io_rdata <= sts_r;
				IO_INTR_OFS:  io_rdata <= intr_r;
				IO_FRAME_NUMBER_OFS: io_rdata <= frame_number_r;
				IO_BASE_LO:   io_rdata <= base_r[15:0];
				IO_BASE_HI:   io_rdata <= base_r[31:16];
				IO_SOF_OFS:   io_rdata <= {8'h00, sof_r};
				IO_PORT0_OFS: io_rdata <= port_r[0];
				IO_PORT1_OFS: io_rdata <= port_r[1];
				IO_LOOP_OFS:  io_rdata <= {8'h00, loop_r}; // R20
				default:      io_rdata <= 16'h0000;
			endcase
		end
	end
endmodule

`default_nettype wire

// >>> usblg_pkg.sv
// constants, register map and carrier types of the legacy trap and wake block
package usblg_pkg;
	// configuration space offsets
	localparam logic [7:0]  CFG_LEGACY_KBD_OFS  = 8'hC0;
	localparam logic [7:0]  CFG_WAKE_PORT_OFS   = 8'hC4;
	localparam logic [15:0] LEGACY_KBD_RST      = 16'h2000;
	localparam logic [7:0]  WAKE_PORT_RST       = 8'h00;
	// legacy control bit positions
	localparam int LK_DATA_RD_EN   = 0;
	localparam int LK_DATA_WR_EN   = 1;
	localparam int LK_CMD_RD_EN    = 2;
	localparam int LK_CMD_WR_EN    = 3;
	localparam int LK_IRQ_SMI_EN   = 4;
	localparam int LK_PASS_EN      = 5;
	localparam int LK_PASS_STATE   = 6;
	localparam int LK_SMI_END_EN   = 7;
	localparam int LK_DATA_RD_FLAG = 8;
	localparam int LK_DATA_WR_FLAG = 9;
	localparam int LK_CMD_RD_FLAG  = 10;
	localparam int LK_CMD_WR_FLAG  = 11;
	localparam int LK_IRQ_FLAG     = 12;
	localparam int LK_PIRQ_EN      = 13;
	localparam int LK_END_FLAG     = 15;
	// w1c flags of the legacy register (bit 12 mirrors the irq and is not cleared here)
	localparam logic [15:0] LK_W1C_MASK = 16'h8F00;
	localparam logic [15:0] LK_RW_MASK  = 16'h20BF;
	// gate pass-through command bytes
	localparam logic [7:0]  GATE_CMD_BYTE = 8'hD1;
	localparam logic [7:0]  GATE_END_BYTE = 8'hFF;
	localparam int          GATE_DATA_BIT = 1;
	// i/o space offsets
	localparam logic [4:0]  IO_CMD_OFS    = 5'h00;
	localparam logic [4:0]  IO_STS_OFS    = 5'h02;
	localparam logic [4:0]  IO_INTR_OFS   = 5'h04;
	localparam logic [4:0]  IO_FRAME_NUMBER_OFS  = 5'h06;
	localparam logic [4:0]  IO_BASE_LO    = 5'h08;
	localparam logic [4:0]  IO_BASE_HI    = 5'h0A;
	localparam logic [4:0]  IO_SOF_OFS    = 5'h0C;
	localparam logic [4:0]  IO_PORT0_OFS  = 5'h10;
	localparam logic [4:0]  IO_PORT1_OFS  = 5'h12;
	localparam logic [4:0]  IO_LOOP_OFS   = 5'h18;
	localparam logic [15:0] CMD_RST       = 16'h0000;
	localparam logic [15:0] STS_RST       = 16'h0000;
	localparam logic [15:0] INTR_RST      = 16'h0000;
	localparam logic [15:0] FRAME_NUMBER_RST     = 16'h0000;
	localparam logic [31:0] BASE_RST      = 32'h0000_0000;
	localparam logic [7:0]  SOF_RST       = 8'h40;
	localparam logic [15:0] PORT_RST      = 16'h0080;
	localparam logic [7:0]  LOOP_RST      = 8'h00;
	// command bits
	localparam int CMD_HC_RESET   = 1;
	localparam int CMD_GLB_RESET  = 2;
	localparam int CMD_GLB_RESUME = 4;
	localparam int CMD_LOOPBACK   = 8;
	localparam logic [15:0] CMD_RW_MASK = 16'h01FF;
	localparam logic [15:0] STS_W1C_MASK = 16'h003F;
	// port status/control bits
	localparam int PS_CONNECT    = 0;
	localparam int PS_CONN_CHG   = 1;
	localparam int PS_ENABLE     = 2;
	localparam int PS_EN_CHG     = 3;
	localparam int PS_RESUME     = 6;
	localparam int PS_PORT_RESET = 9;
	localparam int PS_SUSPEND    = 12;

	typedef struct packed {
		logic       data_rd;
		logic       data_wr;
		logic       cmd_rd;
		logic       cmd_wr;
		logic [7:0] wdata;
	} usblg_kbd_s;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [4:0] addr;
		logic [1:0] be;
		logic [15:0] wdata;
	} usblg_io_s;

	typedef enum logic [1:0] {
		PASS_IDLE,
		PASS_WAIT_DATA,
		PASS_WAIT_END
	} usblg_pass_e;
endpackage

// >>> usblg_top_monitor.sv
// assertion checker for the legacy trap and wake block
`timescale 1ns/10ps
`default_nettype none
module usblg_top_monitor
	import usblg_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// watched ports
	input wire logic        cfg_wr,
	input wire logic [7:0]  cfg_addr,
	input wire logic [15:0] cfg_wdata,
	input wire usblg_io_s   io_req,
	input wire usblg_kbd_s  kbd,
	input wire logic [5:0]  hc_status_set,
	input wire logic        sys_mgmt_interrupt_n,
	input wire logic        wake_request
);
	logic [5:0] en_r;
	logic [1:0] wk_r;
	logic       ie_r;
	wire        lk_wr = cfg_wr && cfg_addr == CFG_LEGACY_KBD_OFS;
	wire        any_kb = kbd.data_rd | kbd.data_wr | kbd.cmd_rd | kbd.cmd_wr;

	// shadow of the enables, so checks stay tied to what software asked for
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			en_r <= 6'h00;
			wk_r <= 2'h0;
			ie_r <= 1'b0;
		end else begin
			if (lk_wr)
				en_r <= cfg_wdata[5:0];
			if (cfg_wr && cfg_addr == CFG_WAKE_PORT_OFS)
				wk_r <= cfg_wdata[1:0];
			if (io_req.wr && io_req.be[0] && io_req.addr == IO_INTR_OFS)
				ie_r <= io_req.wdata[0];
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	sequence trap_hit(s, e);
		s && e && !en_r[5];
	endsequence
	sequence smi_low;
		##2 !sys_mgmt_interrupt_n;
	endsequence

	data_rd_trap_a: assert property (trap_hit(kbd.data_rd, en_r[0]) |-> smi_low)
		else $error("data read trap missed");
	data_wr_trap_a: assert property (trap_hit(kbd.data_wr, en_r[1]) |-> smi_low)
		else $error("data write trap missed");
	cmd_rd_trap_a: assert property (trap_hit(kbd.cmd_rd, en_r[2]) |-> smi_low)
		else $error("command read trap missed");
	cmd_wr_trap_a: assert property (trap_hit(kbd.cmd_wr, en_r[3]) |-> smi_low)
		else $error("command write trap missed");
	pass_quiet_a: assert property (en_r[5] && $past(en_r[5]) |-> sys_mgmt_interrupt_n)
		else $error("interrupt during pass-through");
	smi_release_a: assert property (lk_wr && (cfg_wdata & 16'h8F10) == 16'h8F00
		&& !any_kb |-> ##2 sys_mgmt_interrupt_n) else $error("interrupt not released");
	irq_smi_a: assert property (hc_status_set[0] && ie_r && en_r[4] && !en_r[5]
		|-> ##[1:4] !sys_mgmt_interrupt_n) else $error("controller irq missed");
	wake_gate_a: assert property (wk_r == 2'h0 && $past(wk_r) == 2'h0 |-> !wake_request)
		else $error("wake with ports unwatched");
endmodule

bind usblg_top usblg_top_monitor u_mon (
	.clk(clk), .reset(reset), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
	.cfg_wdata(cfg_wdata), .io_req(io_req), .kbd(kbd), .hc_status_set(hc_status_set),
	.sys_mgmt_interrupt_n(sys_mgmt_interrupt_n), .wake_request(wake_request)
);
`default_nettype wire

// >>> usblg_top_tb.sv
// self-checking bench for the legacy trap and wake block
`timescale 1ns/10ps
`default_nettype none
module usblg_top_tb;
	import usblg_pkg::*;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        cfg_rd = 1'b0;
	logic        cfg_wr = 1'b0;
	logic [7:0]  cfg_addr = 8'h00;
	logic [15:0] cfg_wdata = 16'h0000;
	logic [15:0] cfg_rdata;
	usblg_io_s   io_req = '0;
	logic [15:0] io_rdata;
	usblg_kbd_s  kbd = '0;
	logic [5:0]  hc_status_set = 6'h00;
	logic [1:0]  port_attached = 2'h0;
	logic [1:0]  rwk = 2'h0;
	logic        lrv = 1'b0;
	logic [7:0]  ld = 8'h00;
	logic        smi_n;
	logic        gate;
	logic        irq;
	logic        wake;
	logic [1:0]  pen;
	int          n_fail = 0;
	int          tests_run = 0;
	int          cycles = 0;
	logic [23:0] rv [7] = '{24'h0C0040, 24'h100080, 24'h120080, 24'h020000,
		24'h180000, 24'h000000, 24'h0E0000};

	usblg_top u_dut (
		.clk(clk), .reset(reset), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .io_req(io_req), .io_rdata(io_rdata),
		.kbd(kbd), .hc_status_set(hc_status_set), .loop_rx_valid(lrv), .loop_rx_data(ld),
		.port_attached(port_attached), .port_remote_wake(rwk),
		.sys_mgmt_interrupt_n(smi_n), .address_line_gate(gate), .pci_irq(irq),
		.wake_request(wake), .port_enabled(pen)
	);

	always #5 clk = ~clk;

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			n_fail++;
			wrap_up();
		end
	end

	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic late(int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic done(string t);
		$display("test %s finished", t);
	endtask

	// one bus cycle on either register port; reads compare under a mask
	task automatic acc(bit io, bit wr, logic [7:0] a, logic [15:0] d, logic [15:0] m = 16'hFFFF);
		@(posedge clk);
		if (io)
			io_req <= '{rd: !wr, wr: wr, addr: a[4:0], be: 2'h3, wdata: d};
		else
			{cfg_rd, cfg_wr, cfg_addr, cfg_wdata} <= {!wr, wr, a, d};
		@(posedge clk);
		io_req <= '0;
		cfg_rd <= 1'b0;
		cfg_wr <= 1'b0;
		if (!wr) begin
			@(negedge clk);
			chk($sformatf("%s %h", io ? "io" : "cfg", a), d, (io ? io_rdata : cfg_rdata) & m);
		end
	endtask

	task automatic kb(logic [3:0] s, logic [7:0] b);
		@(posedge clk);
		kbd <= {s, b};
		@(posedge clk);
		kbd <= '0;
	endtask

	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		acc(0, 0, 8'hC0, 16'h2000);
		acc(0, 0, 8'hC4, 16'h0000);
		foreach (rv[i])
			acc(1, 0, rv[i][23:16], rv[i][15:0]);
		done("reset");
		kb(4'h8, 8'h00);
		acc(0, 0, 8'hC0, 16'h2100);
		acc(0, 1, 8'hC0, 16'h2000);
		acc(0, 0, 8'hC0, 16'h2100);
		acc(0, 1, 8'hC0, 16'h2100);
		acc(0, 0, 8'hC0, 16'h2000);
		chk("smi idle", 1'b1, smi_n);
		done("flag");
		for (int i = 0; i < 4; i++) begin
			acc(0, 1, 8'hC0, 16'h2000 | (16'h1 << i));
			kb(4'h8 >> i, 8'h00);
			late(2);
			chk("smi low", 1'b0, smi_n);
			acc(0, 1, 8'hC0, 16'h2000 | (16'h101 << i));
			late(2);
			chk("smi high", 1'b1, smi_n);
		end
		done("traps");
		acc(1, 1, 8'h04, 16'h0001);
		acc(0, 1, 8'hC0, 16'h2010);
		@(posedge clk);
		hc_status_set <= 6'h01;
		@(posedge clk);
		hc_status_set <= 6'h00;
		late(3);
		chk("irq smi", 1'b0, smi_n);
		chk("pci irq", 1'b1, irq);
		acc(1, 0, 8'h02, 16'h0001);
		acc(1, 1, 8'h02, 16'h0001);
		acc(1, 0, 8'h02, 16'h0000);
		late(3);
		chk("irq clear", 1'b1, smi_n);
		done("irq");
		acc(0, 1, 8'hC0, 16'h20A1);
		kb(4'h1, GATE_CMD_BYTE);
		acc(0, 0, 8'hC0, 16'h28E1);
		kb(4'h4, 8'h02);
		late(1);
		chk("gate", 1'b1, gate);
		kb(4'h1, GATE_END_BYTE);
		acc(0, 0, 8'hC0, 16'hAAA1);
		chk("smi held", 1'b1, smi_n);
		kb(4'h1, GATE_CMD_BYTE);
		acc(0, 1, 8'hC0, 16'h2081);
		acc(0, 0, 8'hC0, 16'hAA81);
		late(1);
		chk("end smi", 1'b0, smi_n);
		acc(0, 1, 8'hC0, 16'hAF00);
		kb(4'h1, GATE_CMD_BYTE);
		acc(0, 0, 8'hC0, 16'h2800);
		chk("smi off", 1'b1, smi_n);
		done("pass");
		@(posedge clk);
		port_attached <= 2'h1;
		late(6);
		chk("wake off a", 1'b0, wake);
		acc(0, 1, 8'hC4, 16'h0001);
		late(3);
		chk("wake a", 1'b1, wake);
		acc(0, 1, 8'hC4, 16'h0000);
		port_attached <= 2'h3;
		late(6);
		chk("wake off b", 1'b0, wake);
		acc(0, 1, 8'hC4, 16'h0002);
		late(3);
		chk("wake b", 1'b1, wake);
		done("wake");
		acc(1, 1, 8'h10, 16'h0004);
		acc(1, 0, 8'h10, 16'h0004, 16'h0004);
		chk("port on", 2'h1, pen);
		acc(1, 1, 8'h00, 16'h0002);
		acc(1, 0, 8'h10, 16'h0000, 16'h0004);
		chk("port off", 2'h0, pen);
		acc(1, 1, 8'h00, 16'h0000);
		done("port");
		acc(1, 1, 8'h00, 16'h0100);
		@(posedge clk);
		lrv <= 1'b1;
		ld  <= 8'h5A;
		@(posedge clk);
		lrv <= 1'b0;
		acc(1, 0, 8'h18, 16'h005A);
		acc(1, 1, 8'h00, 16'h0000);
		done("loop");
		acc(1, 1, 8'h10, 16'h1002);
		acc(0, 1, 8'hC4, 16'h0001);
		late(2);
		chk("wake idle", 1'b0, wake);
		@(posedge clk);
		rwk <= 2'h1;
		late(6);
		chk("remote wake", 1'b1, wake);
		done("resume");
		wrap_up();
	end
endmodule
`default_nettype wire
